// file: hw/pot_pkg.sv
// constants for the serial digital potentiometer control block
// Summary of operation
// - serial output changes on each falling serial clock edge during reads
// - serial input sampled on each rising serial clock edge
// - chip select high deselects, output floats; standby unless save runs
// - bus ignored after power-up until a chip select falling edge
// - pause input low while clock low holds sequence state
// - id byte last bit must match address select pin to proceed
// - write protect low blocks setting register writes, not wiper writes
// - serial output tri-stated whenever not driving read data
// - wiper value decoded to exactly one of sixty-four tap enables
// - wiper loaded by serial write, register copy, step, power-up load
// - wiper volatile, loaded from setting register zero at power-up
// - four 6-bit setting registers; changes finish within 10 ms
// - six value bits in low byte positions, upper two read zero
// - save starts on select rise after complete write; busy flag set
// - status read returns the write-busy flag
// - instruction byte: opcode upper four bits, pointer next two
// - id byte: type code, then 110, then address select bit
// - step mode: input high steps up, input low steps down per pulse
package pot_pkg;
    localparam int VAL_W       = 6;
    localparam int NUM_TAPS    = 64;
    localparam int NUM_REGS    = 4;
    localparam int PTR_W       = 2;
    localparam logic [3:0] TYPE_CODE = 4'hA; // arbitrary device type value
    localparam logic [2:0] ID_MID    = 3'h6;
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_STORE = 4'hB;
    localparam logic [3:0] OP_WR_STORE = 4'hC;
    localparam logic [3:0] OP_COPY_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_COPY_TO_STORE = 4'hE;
    localparam logic [3:0] OP_STEP     = 4'h2;
    localparam logic [3:0] OP_STATUS   = 4'h5;
    localparam logic [VAL_W-1:0] VAL_MAX   = 6'h3F;
    localparam logic [VAL_W-1:0] VAL_MIN   = 6'h00;
    localparam logic [VAL_W-1:0] STORE_RST = 6'h00;
    localparam int CLK_MHZ      = 125;
    localparam int SAVE_TIME_MS = 10;
    localparam int SAVE_CYCLES  = SAVE_TIME_MS * CLK_MHZ * 1000;
    localparam int SAVE_CNT_W   = 21;
endpackage

// file: hw/pot_link.sv
// serial-clock domain: shifts in frames and shifts out read data
`timescale 1ns/1ps
module pot_link
    import pot_pkg::*;
(
    input  wire logic             sck_in,
    input  wire logic             cs_n_in,
    input  wire logic             sdi_in,
    input  wire logic             hold_n_in,
    input  wire logic             addr_select_pin_in,
    input  wire logic             rst_in,
    input  wire logic [VAL_W-1:0] rd_val_in,
    output logic                  sdo_out,
    output logic                  sdo_oe_out,
    output logic [3:0]            op_out,
    output logic [PTR_W-1:0]      ptr_out,
    output logic [VAL_W-1:0]      data_out,
    output logic                  cmd_tgl_out,
    output logic                  up_tgl_out,
    output logic                  dn_tgl_out,
    output logic [3:0]            rd_op_out,
    output logic [PTR_W-1:0]      rd_ptr_out
);
    logic [4:0]       bit_cnt_r;
    logic [7:0]       sh_r;
    logic             id_ok_r;
    logic [3:0]       op_r;
    logic [PTR_W-1:0] ptr_r;
    logic [VAL_W-1:0] out_sh_r;
    logic             rd_act_r;
    logic             running;
    logic [7:0]       sh_nxt;

    // pause freezes the sequence
    assign running = hold_n_in;
    assign sh_nxt  = {sh_r[6:0], sdi_in};

    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            bit_cnt_r <= 5'h00;
            sh_r      <= 8'h00;
            id_ok_r   <= 1'b0;
            op_r      <= 4'h0;
            ptr_r     <= '0;
        end else if (running) begin
            sh_r <= sh_nxt;
            if (bit_cnt_r != 5'h18) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (bit_cnt_r == 5'h07) begin
                id_ok_r <= (sh_nxt ==
                            {TYPE_CODE, ID_MID, addr_select_pin_in});
            end
            if (bit_cnt_r == 5'h0F) begin
                op_r  <= sh_nxt[7:4];
                ptr_r <= sh_nxt[3:2];
            end
        end
    end

    // command and step events cross as toggles, cleared with the core
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            op_out      <= 4'h0;
            ptr_out     <= '0;
            data_out    <= '0;
            cmd_tgl_out <= 1'b0;
            up_tgl_out  <= 1'b0;
            dn_tgl_out  <= 1'b0;
        end else if (!cs_n_in && running && id_ok_r) begin
            if (bit_cnt_r == 5'h0F && (sh_nxt[7:4] == OP_COPY_TO_WIPER ||
                sh_nxt[7:4] == OP_COPY_TO_STORE)) begin
                op_out      <= sh_nxt[7:4];
                ptr_out     <= sh_nxt[3:2];
                cmd_tgl_out <= ~cmd_tgl_out;
            end
            if (bit_cnt_r == 5'h17 && (op_r == OP_WR_WIPER ||
                op_r == OP_WR_STORE)) begin
                op_out      <= op_r;
                ptr_out     <= ptr_r;
                data_out    <= sh_nxt[VAL_W-1:0];
                cmd_tgl_out <= ~cmd_tgl_out;
            end
            if (bit_cnt_r >= 5'h10 && op_r == OP_STEP) begin
                if (sdi_in) begin
                    up_tgl_out <= ~up_tgl_out;
                end else begin
                    dn_tgl_out <= ~dn_tgl_out;
                end
            end
        end
    end

    // falling edge shift out, float when idle
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            rd_act_r <= 1'b0;
            out_sh_r <= '0;
            sdo_out  <= 1'b0;
        end else if (running) begin
            if (bit_cnt_r == 5'h10 && id_ok_r && (op_r == OP_RD_WIPER ||
                op_r == OP_RD_STORE || op_r == OP_STATUS)) begin
                rd_act_r <= 1'b1;
                sdo_out  <= 1'b0;
                out_sh_r <= rd_val_in;
            end else if (rd_act_r) begin
                sdo_out  <= (bit_cnt_r >= 5'h12) ? out_sh_r[VAL_W-1] : 1'b0;
                if (bit_cnt_r >= 5'h12) begin
                    out_sh_r <= {out_sh_r[VAL_W-2:0], 1'b0};
                end
                if (bit_cnt_r == 5'h18) begin
                    rd_act_r <= 1'b0;
                end
            end
        end
    end
    assign sdo_oe_out = rd_act_r;
    assign rd_op_out  = op_r;
    assign rd_ptr_out = ptr_r;
endmodule // pot_link

// file: hw/pot_ctrl.sv
// top: register file, save timer and tap decode of the digital pot
`timescale 1ns/1ps
module pot_ctrl
    import pot_pkg::*;
#(
    parameter int SAVE_CYC = SAVE_CYCLES
)(
    input  wire logic                core_clk_in,
    input  wire logic                srst_in,
    input  wire logic                sck_in,
    input  wire logic                cs_n_in,
    input  wire logic                sdi_in,
    input  wire logic                hold_n_in,
    input  wire logic                wp_n_in,
    input  wire logic                addr_select_pin_in,
    output logic                     sdo_out,
    output logic                     sdo_oe_out,
    output logic [NUM_TAPS-1:0]      tap_en_out,
    output logic [VAL_W-1:0]         wiper_value_bits_out,
    output logic                     nv_write_busy_out,
    output logic                     standby_out
);
    logic [VAL_W-1:0]     wiper_position_reg_r;
    logic [VAL_W-1:0]     store_r [NUM_REGS];
    logic                 nv_write_busy_r;
    logic [SAVE_CNT_W-1:0] save_cnt_r;
    logic                 pend_r;
    logic [PTR_W-1:0]     pend_ptr_r;
    logic [VAL_W-1:0]     pend_val_r;
    logic                 armed_r;
    logic                 init_r;
    logic [2:0]           cs_sy_r;
    logic [3:0]           rd_op_w;
    logic [PTR_W-1:0]     rd_ptr_w;
    logic [2:0]           cmd_sy_r;
    logic [2:0]           up_sy_r;
    logic [2:0]           dn_sy_r;
    logic [1:0]           wp_sy_r;
    logic [3:0]           op_w;
    logic [PTR_W-1:0]     ptr_w;
    logic [VAL_W-1:0]     data_w;
    logic                 cmd_tgl_w;
    logic                 up_tgl_w;
    logic                 dn_tgl_w;
    logic                 link_sdo;
    logic                 link_oe;
    logic                 link_cs_n;
    logic [VAL_W-1:0]     rd_val;
    logic                 cmd_ev;
    logic                 up_ev;
    logic                 dn_ev;
    logic                 cs_rise;
    logic                 cs_fall;

    // link held deselected until first select falling edge
    assign link_cs_n = cs_n_in | ~armed_r;

    pot_link u_link (
        .sck_in          (sck_in),
        .cs_n_in         (link_cs_n),
        .sdi_in          (sdi_in),
        .hold_n_in       (hold_n_in),
        .addr_select_pin_in (addr_select_pin_in),
        .rst_in          (srst_in),
        .rd_val_in       (rd_val),
        .sdo_out         (link_sdo),
        .sdo_oe_out      (link_oe),
        .op_out          (op_w),
        .ptr_out         (ptr_w),
        .data_out        (data_w),
        .cmd_tgl_out     (cmd_tgl_w),
        .up_tgl_out      (up_tgl_w),
        .dn_tgl_out      (dn_tgl_w),
        .rd_op_out       (rd_op_w),
        .rd_ptr_out      (rd_ptr_w)
    );

    // read value mux sampled by the link once per read
    // status read returns busy flag
    always_comb begin
        unique case (rd_op_w)
            OP_RD_WIPER: rd_val = wiper_position_reg_r;
            OP_RD_STORE: rd_val = store_r[rd_ptr_w];
            OP_STATUS:   rd_val = {{(VAL_W-1){1'b0}}, nv_write_busy_r};
            default:     rd_val = '0;
        endcase
    end

    // synchronisers for pins and toggles
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cs_sy_r   <= 3'h7;
            wp_sy_r   <= 2'h0;
            cmd_sy_r  <= 3'h0;
            up_sy_r   <= 3'h0;
            dn_sy_r   <= 3'h0;
        end else begin
            cs_sy_r   <= {cs_sy_r[1:0], cs_n_in};
            wp_sy_r   <= {wp_sy_r[0], wp_n_in};
            cmd_sy_r  <= {cmd_sy_r[1:0], cmd_tgl_w};
            up_sy_r   <= {up_sy_r[1:0], up_tgl_w};
            dn_sy_r   <= {dn_sy_r[1:0], dn_tgl_w};
        end
    end
    assign cmd_ev  = cmd_sy_r[2] ^ cmd_sy_r[1];
    assign up_ev   = up_sy_r[2] ^ up_sy_r[1];
    assign dn_ev   = dn_sy_r[2] ^ dn_sy_r[1];
    assign cs_rise = cs_sy_r[1] & ~cs_sy_r[2];
    assign cs_fall = ~cs_sy_r[1] & cs_sy_r[2];

    // arm on first select falling edge
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            armed_r <= 1'b0;
        end else if (cs_fall) begin
            armed_r <= 1'b1;
        end
    end

    // wiper update paths, power-up load first
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wiper_position_reg_r <= VAL_MIN;
            init_r               <= 1'b1;
        end else if (init_r) begin
            wiper_position_reg_r <= store_r[0];
            init_r               <= 1'b0;
        end else if (cmd_ev && op_w == OP_WR_WIPER) begin
            wiper_position_reg_r <= data_w;
        end else if (cmd_ev && op_w == OP_COPY_TO_WIPER) begin
            wiper_position_reg_r <= store_r[ptr_w];
        end else if (up_ev && wiper_position_reg_r != VAL_MAX) begin
            wiper_position_reg_r <= wiper_position_reg_r + 6'h01;
        end else if (dn_ev && wiper_position_reg_r != VAL_MIN) begin
            wiper_position_reg_r <= wiper_position_reg_r - 6'h01;
        end
    end

    // pending save captured on a full write; dropped if incomplete
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pend_r     <= 1'b0;
            pend_ptr_r <= '0;
            pend_val_r <= '0;
        end else if (cmd_ev && wp_sy_r[1] && !nv_write_busy_r &&
                     (op_w == OP_WR_STORE || op_w == OP_COPY_TO_STORE)) begin
            pend_r     <= 1'b1;
            pend_ptr_r <= ptr_w;
            pend_val_r <= (op_w == OP_WR_STORE) ? data_w
                                                : wiper_position_reg_r;
        end else if (cs_rise || cs_fall) begin
            pend_r <= 1'b0;
        end
    end

    // save on select rise, busy for the save time
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            nv_write_busy_r <= 1'b0;
            save_cnt_r      <= '0;
            for (int i = 0; i < NUM_REGS; i++) begin
                store_r[i] <= STORE_RST;
            end
        end else if (nv_write_busy_r) begin
            if (save_cnt_r == SAVE_CNT_W'(SAVE_CYC - 1)) begin
                nv_write_busy_r     <= 1'b0;
                store_r[pend_ptr_r] <= pend_val_r;
            end else begin
                save_cnt_r <= save_cnt_r + 1'b1;
            end
        end else if (cs_rise && pend_r) begin
            nv_write_busy_r <= 1'b1;
            save_cnt_r      <= '0;
        end
    end

    generate
        for (genvar t = 0; t < NUM_TAPS; t++) begin : g_tap
            always_ff @(posedge core_clk_in) begin
                if (srst_in) begin
                    tap_en_out[t] <= (t == 0);
                end else begin
                    tap_en_out[t] <= (wiper_position_reg_r == VAL_W'(t));
                end
            end
        end
    endgenerate

    // registered status outputs; standby when idle and not saving
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wiper_value_bits_out <= '0;
            nv_write_busy_out    <= 1'b0;
            standby_out          <= 1'b0;
        end else begin
            wiper_value_bits_out <= wiper_position_reg_r;
            nv_write_busy_out    <= nv_write_busy_r;
            standby_out          <= cs_sy_r[1] & ~nv_write_busy_r;
        end
    end

    // serial output comes from link flip-flops on the serial clock
    assign sdo_out    = link_sdo;
    assign sdo_oe_out = link_oe;
endmodule // pot_ctrl

// file: test/pot_ctrl_monitor.sv
// assertion checker for the digital pot control block
`timescale 1ns/1ps
module pot_ctrl_monitor
    import pot_pkg::*;
#(
    parameter int SAVE_CYC = SAVE_CYCLES
)(
    input wire logic                core_clk_in,
    input wire logic                srst_in,
    input wire logic                sck_in,
    input wire logic                cs_n_in,
    input wire logic                sdi_in,
    input wire logic                hold_n_in,
    input wire logic                wp_n_in,
    input wire logic                addr_select_pin_in,
    input wire logic                sdo_out,
    input wire logic                sdo_oe_out,
    input wire logic [NUM_TAPS-1:0] tap_en_out,
    input wire logic [VAL_W-1:0]    wiper_value_bits_out,
    input wire logic                nv_write_busy_out,
    input wire logic                standby_out
);
    int busy_cnt_r;
    // counts cycles of the running save
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !nv_write_busy_out) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end
    default clocking dcb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);
    a_tap_onehot: assert property ($onehot(tap_en_out))
        else $error("tap enables not one-hot");
    a_tap_follows_wiper: assert property (
        $stable(wiper_value_bits_out)[*3] |->
        tap_en_out == (64'h1 << wiper_value_bits_out))
        else $error("tap enable does not match wiper");
    a_oe_deselected: assert property (cs_n_in[*2] |-> !sdo_oe_out)
        else $error("serial output driven while deselected");
    a_standby_idle: assert property (
        (cs_n_in && !nv_write_busy_out)[*6] |-> standby_out)
        else $error("no standby while idle");
    a_standby_exit: assert property (
        $fell(cs_n_in) |-> ##[1:6] !standby_out)
        else $error("standby kept while selected");
    a_save_bounded: assert property (
        nv_write_busy_out |-> busy_cnt_r < SAVE_CYC + 2)
        else $error("save runs too long");
    a_save_on_release: assert property (
        $rose(nv_write_busy_out) |-> cs_n_in && !standby_out)
        else $error("save started while selected");
    a_save_protected: assert property (
        $rose(nv_write_busy_out) |-> wp_n_in)
        else $error("save started under write protect");
    a_wiper_quiet: assert property (
        cs_n_in[*8] |-> $stable(wiper_value_bits_out))
        else $error("wiper changed while deselected");
endmodule // pot_ctrl_monitor

bind pot_ctrl pot_ctrl_monitor #(.SAVE_CYC(SAVE_CYC)) i_pot_ctrl_monitor (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .sck_in(sck_in),
    .cs_n_in(cs_n_in), .sdi_in(sdi_in), .hold_n_in(hold_n_in),
    .wp_n_in(wp_n_in), .addr_select_pin_in(addr_select_pin_in),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .tap_en_out(tap_en_out),
    .wiper_value_bits_out(wiper_value_bits_out),
    .nv_write_busy_out(nv_write_busy_out), .standby_out(standby_out));

// file: test/spi_host_model.sv
// serial bus master model driving select, clock and data of the pot
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic sdo_in,
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    output logic      hold_n_out
);
    localparam realtime HALF = 7.5;
    logic [7:0] rx_r;
    // pause input kept high when unused
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
        hold_n_out = 1'b1;
        rx_r = 8'h00;
    end
    // select falls first, held low all frame
    task automatic frame(input logic [23:0] tx, input int n, input int hp);
        cs_n_out = 1'b0;
        #(4*HALF);
        for (int i = 0; i < n; i++) begin
            sdi_out = tx[23-i];
            // pause and resume while sck low
            if (i == hp) begin
                hold_n_out = 1'b0;
                for (int j = 0; j < 3; j++) begin
                    sdi_out = ~sdi_out;
                    #HALF sck_out = 1'b1;
                    #HALF sck_out = 1'b0;
                end
                hold_n_out = 1'b1;
                sdi_out = tx[23-i];
            end
            // msb first, data set while sck low
            #HALF sck_out = 1'b1;
            rx_r = {rx_r[6:0], sdo_in};
            #HALF sck_out = 1'b0;
        end
        #HALF cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule // spi_host_model

// file: test/pot_ctrl_test.sv
// self-checking bench for the digital pot control block
`timescale 1ns/1ps
module pot_ctrl_test;
    import pot_pkg::*;
    localparam int SAVE_SIM = 200;
    logic                core_clk_in;
    logic                srst_in;
    logic                wp_n_in;
    logic                a_sel;
    logic                sck;
    logic                cs_n;
    logic                sdi;
    logic                hold_n;
    logic                sdo;
    logic                sdo_oe;
    logic                busy;
    logic                stby;
    logic [NUM_TAPS-1:0] tap_en;
    logic [VAL_W-1:0]    wiper;
    int                  n_mismatch;
    int                  compares;

    pot_ctrl #(.SAVE_CYC(SAVE_SIM)) i_pot_ctrl (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .sck_in(sck),
        .cs_n_in(cs_n), .sdi_in(sdi), .hold_n_in(hold_n),
        .wp_n_in(wp_n_in), .addr_select_pin_in(a_sel), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .tap_en_out(tap_en),
        .wiper_value_bits_out(wiper), .nv_write_busy_out(busy),
        .standby_out(stby));
    // released serial line reads its pull-up level
    spi_host_model i_spi_host_model (
        .sdo_in(sdo_oe ? sdo : 1'b1), .sck_out(sck), .cs_n_out(cs_n),
        .sdi_out(sdi),
        .hold_n_out(hold_n));

    always #4 core_clk_in = ~core_clk_in;

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
            n_mismatch++;
        end
    endtask
    // id byte: type, fixed bits, address bit one
    task automatic cmd(input logic [3:0] op, input logic [1:0] p,
                       input logic [7:0] d, input int n, input int hp);
        i_spi_host_model.frame({TYPE_CODE, ID_MID, 1'b1, op, p, 2'b00, d},
                               n, hp);
        repeat (8) @(posedge core_clk_in);
        #1;
    endtask
    task automatic wait_idle;
        int k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge core_clk_in);
            #1;
            k++;
        end
        if (k == 1000) begin
            n_mismatch++;
            conclude();
        end
        #1;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
    initial begin
        core_clk_in = 1'b0;
        srst_in = 1'b1;
        wp_n_in = 1'b1;
        a_sel = 1'b1;
        n_mismatch = 0;
        compares = 0;
        repeat (4) @(posedge core_clk_in);
        #1 srst_in = 1'b0;
        i_spi_host_model.frame(24'h0, 0, -1);
        repeat (4) @(posedge core_clk_in);
        #1;
        chk("power_up", wiper, 64'(STORE_RST));
        cmd(OP_WR_WIPER, 2'h0, 8'h2A, 24, -1);
        chk("wiper", wiper, 64'h2A);
        chk("tap", tap_en, 64'h1 << 6'h2A);
        cmd(OP_RD_WIPER, 2'h0, 8'h00, 24, -1);
        chk("rd_wiper", i_spi_host_model.rx_r, 8'h2A);
        chk("oe", sdo_oe, 1'b0);
        $display("done: wiper write and read");
        cmd(OP_WR_WIPER, 2'h0, 8'h0C, 24, 12);
        chk("paused", wiper, 64'h0C);
        cmd(OP_WR_WIPER, 2'h0, 8'h33, 20, -1);
        chk("aborted", wiper, 64'h0C);
        a_sel = 1'b0;
        cmd(OP_WR_WIPER, 2'h0, 8'h33, 24, -1);
        chk("addr_miss", wiper, 64'h0C);
        a_sel = 1'b1;
        $display("done: pause, abort, address");
        cmd(OP_WR_STORE, 2'h2, 8'h15, 24, -1);
        chk("busy", busy, 1'b1);
        chk("stby_busy", stby, 1'b0);
        cmd(OP_STATUS, 2'h0, 8'h00, 24, -1);
        chk("status1", i_spi_host_model.rx_r, 8'h01);
        wait_idle();
        chk("stby", stby, 1'b1);
        cmd(OP_STATUS, 2'h0, 8'h00, 24, -1);
        chk("status0", i_spi_host_model.rx_r, 8'h00);
        cmd(OP_RD_STORE, 2'h2, 8'h00, 24, -1);
        chk("store2", i_spi_host_model.rx_r, 8'h15);
        $display("done: store write");
        wp_n_in = 1'b0;
        cmd(OP_WR_STORE, 2'h3, 8'h11, 24, -1);
        chk("wp_busy", busy, 1'b0);
        cmd(OP_WR_WIPER, 2'h0, 8'h07, 24, -1);
        chk("wp_wiper", wiper, 64'h07);
        wp_n_in = 1'b1;
        cmd(OP_RD_STORE, 2'h3, 8'h00, 24, -1);
        chk("store3", i_spi_host_model.rx_r, 8'h00);
        $display("done: write protect");
        cmd(OP_COPY_TO_WIPER, 2'h2, 8'h00, 16, -1);
        chk("copy_wiper", wiper, 64'h15);
        cmd(OP_COPY_TO_STORE, 2'h1, 8'h00, 16, -1);
        wait_idle();
        cmd(OP_RD_STORE, 2'h1, 8'h00, 24, -1);
        chk("store1", i_spi_host_model.rx_r, 8'h15);
        $display("done: register copy");
        cmd(OP_WR_WIPER, 2'h0, 8'h3E, 24, -1);
        cmd(OP_STEP, 2'h0, 8'hE0, 19, -1);
        chk("step_up", wiper, 64'h3F);
        cmd(OP_WR_WIPER, 2'h0, 8'h01, 24, -1);
        cmd(OP_STEP, 2'h0, 8'h20, 19, -1);
        chk("step_dn", wiper, 64'h01);
        $display("done: step mode");
        conclude();
    end
endmodule // pot_ctrl_test
